// file: rtl/snz_params.svh
// timing and reset constants for the snooze receive wake block
// assumes a single 125 MHz clock and a fixed serial bit rate
`ifndef SNZ_PARAMS_SVH
`define SNZ_PARAMS_SVH

`define SNZ_CLK_HZ        125000000
`define SNZ_BIT_RATE_BPS  90000
`define SNZ_BIT_CYC       (`SNZ_CLK_HZ / `SNZ_BIT_RATE_BPS)
`define SNZ_HALF_CYC      (`SNZ_BIT_CYC / 2)
`define SNZ_DATA_BITS     8
`define SNZ_CNT_RST       8'h00
`define SNZ_ADDR_RST      8'h00

`endif

// file: rtl/snz_pkg.sv
// types shared by the snooze receive wake block
// assumes snz_params.svh is included by the modules that use constants
package snz_pkg;

    typedef enum logic [3:0] {
        SNZ_NORMAL  = 4'h1,
        SNZ_STANDBY = 4'h2,
        SNZ_SNOOZE  = 4'h4,
        SNZ_XFER    = 4'h8
    } snz_mode_t;

    typedef enum logic [3:0] {
        SNZ_RX_IDLE  = 4'h1,
        SNZ_RX_START = 4'h2,
        SNZ_RX_DATA  = 4'h4,
        SNZ_RX_STOP  = 4'h8
    } snz_rx_state_t;

    typedef struct packed {
        snz_rx_state_t state;
        logic [10:0]   cnt;
        logic [2:0]    bitn;
        logic [7:0]    shf;
        logic          prev;
        logic [7:0]    data;
        logic          full;
        logic          err;
        logic          start;
    } snz_rx_st_t;

    typedef struct packed {
        snz_mode_t  mode;
        logic [7:0] remaining;
        logic [7:0] addr;
        logic [7:0] wr_addr;
        logic [7:0] data;
        logic       buf_we;
        logic       release_irq;
        logic       mismatch;
        logic       rx_error;
    } snz_ctl_st_t;

endpackage

// file: rtl/snz_uart_rx.sv
// asynchronous serial receiver: 8 data bits, lsb first, no parity, 1 stop
// assumes the receive input is already synchronous to clock_i
`timescale 1ns/1ps
`include "snz_params.svh"

module snz_uart_rx (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       rxd_i,
    output logic            start_o,
    output logic            full_o,
    output logic            err_o,
    output logic [7:0]      data_o
);

    snz_pkg::snz_rx_st_t rx_ff;
    snz_pkg::snz_rx_st_t nxt_rx;

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    always_comb begin
        nxt_rx       = rx_ff;
        nxt_rx.full  = 1'b0;
        nxt_rx.err   = 1'b0;
        nxt_rx.start = 1'b0;
        nxt_rx.prev  = rxd_i;
        unique case (rx_ff.state)
            snz_pkg::SNZ_RX_IDLE: begin
                if (rx_ff.prev && !rxd_i) begin
                    nxt_rx.state = snz_pkg::SNZ_RX_START;
                    nxt_rx.cnt   = 11'(`SNZ_HALF_CYC - 1);
                    nxt_rx.start = 1'b1;
                end
            end
            snz_pkg::SNZ_RX_START: begin
                if (rx_ff.cnt != 11'h000) begin
                    nxt_rx.cnt = rx_ff.cnt - 11'h001;
                end else if (!rxd_i) begin
                    nxt_rx.state = snz_pkg::SNZ_RX_DATA;
                    nxt_rx.cnt   = 11'(`SNZ_BIT_CYC - 1);
                    nxt_rx.bitn  = 3'h0;
                end else begin
                    // glitch shorter than half a bit: drop it
                    nxt_rx.state = snz_pkg::SNZ_RX_IDLE;
                end
            end
            snz_pkg::SNZ_RX_DATA: begin
                if (rx_ff.cnt != 11'h000) begin
                    nxt_rx.cnt = rx_ff.cnt - 11'h001;
                end else begin
                    nxt_rx.shf = {rxd_i, rx_ff.shf[7:1]};
                    nxt_rx.cnt = 11'(`SNZ_BIT_CYC - 1);
                    if (rx_ff.bitn == 3'h7) begin
                        nxt_rx.state = snz_pkg::SNZ_RX_STOP;
                    end else begin
                        nxt_rx.bitn = rx_ff.bitn + 3'h1;
                    end
                end
            end
            snz_pkg::SNZ_RX_STOP: begin
                if (rx_ff.cnt != 11'h000) begin
                    nxt_rx.cnt = rx_ff.cnt - 11'h001;
                end else begin
                    nxt_rx.state = snz_pkg::SNZ_RX_IDLE;
                    if (rxd_i) begin
                        nxt_rx.data = rx_ff.shf;
                        nxt_rx.full = 1'b1;
                    end else begin
                        nxt_rx.err = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_ff <= '{state: snz_pkg::SNZ_RX_IDLE, cnt: 11'h000, bitn: 3'h0,
                       shf: 8'h00, prev: 1'b1, data: 8'h00, full: 1'b0,
                       err: 1'b0, start: 1'b0};
        end else begin
            rx_ff <= nxt_rx;
        end
    end

    assign start_o = rx_ff.start;
    assign full_o  = rx_ff.full;
    assign err_o   = rx_ff.err;
    assign data_o  = rx_ff.data;

endmodule

// file: rtl/snz_wake.sv
// snooze sequencing around serial reception with a byte transfer engine
// assumes software requests standby by a pulse and reads the buffer writes
`timescale 1ns/1ps
`include "snz_params.svh"

// Functional notes
// [RULE1] in standby, a start-bit falling edge enters snooze and starts reception
// [RULE2] after one byte is moved to the buffer, snooze returns to standby
// [RULE3] cycle repeats per byte until count reached; release interrupt wakes to normal (code: count only advances with write-back enabled)
// [RULE4] a received byte unequal to the compare value ends snooze
// [RULE5] release interrupt comes from transfer end, transfer triggered by receive full
// [RULE6] interrupt only after all transfers, not each, unless per-transfer selected
// [RULE7] each transfer writes back its remaining count when write-back is enabled
// [RULE8] each transfer moves one received byte to the next buffer location
// [RULE9] repeat mode without per-transfer interrupts never releases snooze
// [RULE10] far transmitter sends 8N1 frames at the set rate, no flow control
module snz_wake (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       standby_req_i,
    input  wire logic       serial_receive_input_i,
    input  wire logic [7:0] xfer_count_i,
    input  wire logic [7:0] compare_data_register_i,
    input  wire logic       compare_en_i,
    input  wire logic       per_transfer_interrupt_select_i,
    input  wire logic       repeat_mode_i,
    input  wire logic       writeback_en_i,
    output logic [3:0]      mode_o,
    output logic            buf_we_o,
    output logic [7:0]      buf_addr_o,
    output logic [7:0]      buf_data_o,
    output logic [7:0]      remaining_o,
    output logic            release_irq_o,
    output logic            mismatch_o,
    output logic            rx_error_o
);

    snz_pkg::snz_ctl_st_t st_ff;
    snz_pkg::snz_ctl_st_t nxt_st;

    logic       rx_start;
    logic       rx_full;
    logic       rx_err;
    logic [7:0] rx_data;
    logic       miss_w;
    logic       done_w;
    logic       last_w;

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    snz_uart_rx u_rx (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .rxd_i   (serial_receive_input_i),
        .start_o (rx_start),
        .full_o  (rx_full),
        .err_o   (rx_err),
        .data_o  (rx_data)
    );

    // ----------------------------------------
    // mode sequencer and transfer engine
    // ----------------------------------------
    assign miss_w = compare_en_i && (rx_data != compare_data_register_i);
    assign last_w = (st_ff.remaining == 8'h01);
    // without write-back the count is frozen, so only per-transfer can finish
    assign done_w = per_transfer_interrupt_select_i ||
                    (writeback_en_i && !repeat_mode_i && last_w); // [RULE6] [RULE9]

    always_comb begin
        nxt_st             = st_ff;
        nxt_st.buf_we      = 1'b0;
        nxt_st.release_irq = 1'b0;
        nxt_st.mismatch    = 1'b0;
        nxt_st.rx_error    = 1'b0;
        unique case (st_ff.mode)
            snz_pkg::SNZ_NORMAL: begin
                if (standby_req_i) begin
                    nxt_st.mode      = snz_pkg::SNZ_STANDBY;
                    nxt_st.remaining = xfer_count_i;
                    nxt_st.addr      = `SNZ_ADDR_RST;
                end
            end
            snz_pkg::SNZ_STANDBY: begin
                if (rx_start) begin
                    nxt_st.mode = snz_pkg::SNZ_SNOOZE; // [RULE1]
                end
            end
            snz_pkg::SNZ_SNOOZE: begin
                if (rx_full && miss_w) begin
                    nxt_st.mode     = snz_pkg::SNZ_NORMAL; // [RULE4]
                    nxt_st.mismatch = 1'b1;
                end else if (rx_full) begin
                    // receive full is the transfer trigger
                    nxt_st.mode    = snz_pkg::SNZ_XFER; // [RULE5]
                    nxt_st.data    = rx_data; // [RULE8]
                    nxt_st.buf_we  = 1'b1;
                    nxt_st.wr_addr = st_ff.addr;
                    nxt_st.addr    = st_ff.addr + 8'h01;
                end else if (rx_err) begin
                    // a broken frame is dropped and the block sleeps again
                    nxt_st.mode     = snz_pkg::SNZ_STANDBY;
                    nxt_st.rx_error = 1'b1;
                end
            end
            snz_pkg::SNZ_XFER: begin
                if (writeback_en_i) begin
                    if (repeat_mode_i && last_w) begin
                        nxt_st.remaining = xfer_count_i; // [RULE9]
                    end else begin
                        nxt_st.remaining = st_ff.remaining - 8'h01; // [RULE7]
                    end
                end
                if (done_w) begin
                    nxt_st.mode        = snz_pkg::SNZ_NORMAL; // [RULE3]
                    nxt_st.release_irq = 1'b1; // [RULE5]
                end else begin
                    nxt_st.mode = snz_pkg::SNZ_STANDBY; // [RULE2]
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '{mode: snz_pkg::SNZ_NORMAL, remaining: `SNZ_CNT_RST,
                       addr: `SNZ_ADDR_RST, wr_addr: `SNZ_ADDR_RST,
                       data: 8'h00, buf_we: 1'b0, release_irq: 1'b0,
                       mismatch: 1'b0, rx_error: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mode_o        = st_ff.mode;
    assign buf_we_o      = st_ff.buf_we;
    assign buf_addr_o    = st_ff.wr_addr;
    assign buf_data_o    = st_ff.data;
    assign remaining_o   = st_ff.remaining;
    assign release_irq_o = st_ff.release_irq;
    assign mismatch_o    = st_ff.mismatch;
    assign rx_error_o    = st_ff.rx_error;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_start_wakes;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_STANDBY) && rx_start |=> (st_ff.mode == snz_pkg::SNZ_SNOOZE);
    endproperty
    a_start_wakes: assert property (p_start_wakes) else $error("start edge did not enter snooze"); // [RULE1]

    property p_back_to_standby;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_XFER) && !done_w |=> (st_ff.mode == snz_pkg::SNZ_STANDBY) && !release_irq_o;
    endproperty
    a_back_to_standby: assert property (p_back_to_standby) else $error("no return to standby"); // [RULE2]

    property p_count_release;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_XFER) && writeback_en_i && !repeat_mode_i && last_w
        |=> release_irq_o && (st_ff.mode == snz_pkg::SNZ_NORMAL) && (remaining_o == 8'h00);
    endproperty
    a_count_release: assert property (p_count_release) else $error("last byte did not release"); // [RULE3]

    property p_mismatch_ends;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_SNOOZE) && rx_full && miss_w
        |=> mismatch_o && !buf_we_o && (st_ff.mode == snz_pkg::SNZ_NORMAL);
    endproperty
    a_mismatch_ends: assert property (p_mismatch_ends) else $error("mismatch did not end snooze"); // [RULE4]

    property p_release_source;
        @(posedge clock_i) disable iff (!rst_n_i)
        release_irq_o |-> $past(st_ff.mode == snz_pkg::SNZ_XFER) && $past(buf_we_o);
    endproperty
    a_release_source: assert property (p_release_source) else $error("release without transfer"); // [RULE5]

    property p_no_early_irq;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_XFER) && !per_transfer_interrupt_select_i && (st_ff.remaining > 8'h01)
        |=> !release_irq_o [*2];
    endproperty
    a_no_early_irq: assert property (p_no_early_irq) else $error("interrupt before count done"); // [RULE6]

    property p_writeback;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_XFER) && writeback_en_i && !(repeat_mode_i && last_w)
        |=> remaining_o == $past(remaining_o) - 8'h01;
    endproperty
    a_writeback: assert property (p_writeback) else $error("count not written back"); // [RULE7]

    property p_byte_move;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_SNOOZE) && rx_full && !miss_w
        |=> buf_we_o && (buf_data_o == $past(rx_data)) && (buf_addr_o == $past(st_ff.addr));
    endproperty
    a_byte_move: assert property (p_byte_move) else $error("byte not moved to buffer"); // [RULE8]

    // a zero count stands for 256, so a zero reload is still a full round
    property p_repeat_silent;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_XFER) && repeat_mode_i && !per_transfer_interrupt_select_i
        |=> !release_irq_o &&
            ((remaining_o != 8'h00) || ($past(xfer_count_i) == 8'h00) || !$past(writeback_en_i));
    endproperty
    a_repeat_silent: assert property (p_repeat_silent) else $error("repeat mode released"); // [RULE9]

    // a broken frame drops the byte and puts the block back to sleep
    property p_error_resleeps;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_SNOOZE) && rx_err && !rx_full
        |=> rx_error_o && !buf_we_o && (st_ff.mode == snz_pkg::SNZ_STANDBY);
    endproperty
    a_error_resleeps: assert property (p_error_resleeps) else $error("receive error did not resleep"); // [RULE2]

    property p_write_in_xfer;
        @(posedge clock_i) disable iff (!rst_n_i)
        buf_we_o |-> (st_ff.mode == snz_pkg::SNZ_XFER);
    endproperty
    a_write_in_xfer: assert property (p_write_in_xfer) else $error("buffer write outside transfer"); // [RULE8]

    c_release: cover property (@(posedge clock_i) disable iff (!rst_n_i) release_irq_o);
    c_mismatch: cover property (@(posedge clock_i) disable iff (!rst_n_i) mismatch_o);
    c_rx_error: cover property (@(posedge clock_i) disable iff (!rst_n_i) rx_error_o);
    c_reload: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_XFER) && repeat_mode_i && last_w);
    c_resleep: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        (st_ff.mode == snz_pkg::SNZ_XFER) ##1 (st_ff.mode == snz_pkg::SNZ_STANDBY));

endmodule

// file: sim/snz_tx_model.sv
// far-side serial transmitter model for the snooze receive wake block
// assumes the bench pulses send_i for one cycle while busy_o is low
// and changes its inputs on the falling edge; the line moves on the rising edge
`timescale 1ns/1ps

module snz_tx_model #(
    parameter int BIT_CYC = 1388
) (
    input  wire logic       clock_i,
    input  wire logic       send_i,
    input  wire logic [7:0] data_i,
    input  wire logic       stop_low_i,
    output logic            line_o,
    output logic            busy_o
);
    // ----------------------------------------
    // frame shifter
    // ----------------------------------------
    logic [9:0] frame;
    int         cnt;
    int         nbit;

    initial begin
        line_o = 1'b1;
        busy_o = 1'b0;
    end

    // start low, 8 data lsb first, one stop high, no flow control
    // stop_low_i breaks the stop bit so the receive error path is reached
    always @(posedge clock_i) begin
        if (busy_o) begin
            if (cnt == BIT_CYC - 1) begin
                cnt = 0;
                nbit++;
                if (nbit == 10) begin
                    busy_o <= 1'b0;
                    line_o <= 1'b1;
                end else begin
                    line_o <= frame[nbit];
                end
            end else begin
                cnt++;
            end
        end else if (send_i) begin
            frame  = {~stop_low_i, data_i, 1'b0};
            nbit   = 0;
            cnt    = 0;
            busy_o <= 1'b1;
            line_o <= 1'b0;
        end
    end
endmodule

// file: sim/snz_wake_test.sv
// self-checking bench for snz_wake with a serial transmitter model
// assumes the fixed 90 kbps bit time from snz_params.svh
`timescale 1ns/1ps
`include "snz_params.svh"

`define SNZ_CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("BAD t=%0t %s got %h exp %h", $time, m, a, e); end end

module snz_wake_test;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic       clock_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       standby_req = 1'b0;
    logic       line;
    logic [7:0] count = 8'h00;
    logic [7:0] cmp = 8'h00;
    logic       cmp_en = 1'b0;
    logic       per_sel = 1'b0;
    logic       rpt = 1'b0;
    logic       wb = 1'b1;
    logic       send = 1'b0;
    logic       stop_low = 1'b0;
    logic       rx_err;
    logic [7:0] tx_data = 8'h00;
    logic       busy;
    logic [3:0] mode;
    logic       buf_we;
    logic [7:0] buf_addr;
    logic [7:0] buf_data;
    logic [7:0] remaining;
    logic       irq;
    logic       mismatch;
    logic [7:0] wa_q[$];
    logic [7:0] wd_q[$];
    int         fails = 0;
    int         tests_run = 0;
    int         irq_n = 0;
    int         mis_n = 0;
    int         err_n = 0;

    always #4 clock_i = ~clock_i;

    snz_tx_model #(.BIT_CYC(`SNZ_BIT_CYC)) tx (.clock_i(clock_i), .send_i(send), .data_i(tx_data),
        .stop_low_i(stop_low), .line_o(line), .busy_o(busy));

    snz_wake dut (
        .clock_i                         (clock_i),
        .rst_n_i                         (rst_n_i),
        .standby_req_i                   (standby_req),
        .serial_receive_input_i          (line),
        .xfer_count_i                    (count),
        .compare_data_register_i         (cmp),
        .compare_en_i                    (cmp_en),
        .per_transfer_interrupt_select_i (per_sel),
        .repeat_mode_i                   (rpt),
        .writeback_en_i                  (wb),
        .mode_o                          (mode),
        .buf_we_o                        (buf_we),
        .buf_addr_o                      (buf_addr),
        .buf_data_o                      (buf_data),
        .remaining_o                     (remaining),
        .release_irq_o                   (irq),
        .mismatch_o                      (mismatch),
        .rx_error_o                      (rx_err)
    );

    // single-cycle pulses are logged here so no scenario can miss one
    always @(posedge clock_i) begin
        if (buf_we === 1'b1) begin
            wa_q.push_back(buf_addr);
            wd_q.push_back(buf_data);
        end
        if (irq === 1'b1) irq_n++;
        if (mismatch === 1'b1) mis_n++;
        if (rx_err === 1'b1) err_n++;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic enter_standby(input logic [7:0] n);
        wa_q.delete();
        wd_q.delete();
        irq_n = 0;
        mis_n = 0;
        err_n = 0;
        count = n;
        @(negedge clock_i) standby_req = 1'b1;
        @(negedge clock_i) standby_req = 1'b0;
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_STANDBY), "standby entry")
        `SNZ_CHK(remaining, n, "count load")
    endtask

    task automatic send_byte(input logic [7:0] b);
        int i;
        @(negedge clock_i) begin
            send = 1'b1;
            tx_data = b;
        end
        @(negedge clock_i) send = 1'b0;
        repeat (700) @(negedge clock_i);
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_SNOOZE), "snooze on start edge")
        for (i = 0; i < 16000 && busy === 1'b1; i++) @(negedge clock_i);
        repeat (2) @(negedge clock_i);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_count_run();
        enter_standby(8'h02);
        send_byte(8'h5a);
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_STANDBY), "back to standby")
        `SNZ_CHK(irq_n, 0, "no early release")
        `SNZ_CHK(remaining, 8'h01, "count written back")
        send_byte(8'ha5);
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_NORMAL), "wake after count")
        `SNZ_CHK(irq_n, 1, "one release on transfer end")
        `SNZ_CHK(wa_q.size(), 2, "two buffer writes")
        `SNZ_CHK({wa_q[0], wd_q[0], wa_q[1], wd_q[1]}, 32'h005a_01a5, "buffer order")
    endtask

    task automatic sc_per_transfer();
        per_sel = 1'b1;
        wb = 1'b0;
        enter_standby(8'h03);
        send_byte(8'h81);
        `SNZ_CHK(irq_n, 1, "release per transfer")
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_NORMAL), "wake per transfer")
        `SNZ_CHK(remaining, 8'h03, "count frozen without write-back")
        per_sel = 1'b0;
        wb = 1'b1;
    endtask

    task automatic sc_mismatch();
        cmp_en = 1'b1;
        cmp = 8'h3c;
        enter_standby(8'h02);
        send_byte(8'hc3);
        `SNZ_CHK(mis_n, 1, "mismatch wake")
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_NORMAL), "normal after mismatch")
        `SNZ_CHK(wa_q.size(), 0, "no write on mismatch")
        cmp_en = 1'b0;
    endtask

    task automatic sc_repeat();
        rpt = 1'b1;
        enter_standby(8'h01);
        send_byte(8'h77);
        `SNZ_CHK(irq_n, 0, "repeat never releases")
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_STANDBY), "repeat stays asleep")
        `SNZ_CHK(remaining, 8'h01, "repeat reload")
        `SNZ_CHK(wd_q.size() == 1 && wd_q[0] === 8'h77, 1'b1, "repeat byte stored")
        // a low stop bit drops the frame and the block stays asleep
        stop_low = 1'b1;
        send_byte(8'h3e);
        stop_low = 1'b0;
        `SNZ_CHK(err_n, 1, "receive error flagged")
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_STANDBY), "standby after error")
        `SNZ_CHK(wa_q.size(), 1, "no write on error")
        `SNZ_CHK(remaining, 8'h01, "count kept on error")
        rpt = 1'b0;
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        `SNZ_CHK(mode, 4'(snz_pkg::SNZ_NORMAL), "reset mode")
        sc_count_run();
        sc_per_transfer();
        sc_mismatch();
        sc_repeat();
        close_out();
    end

    // six frames of about 13900 cycles each plus margin
    initial begin
        repeat (100000) @(posedge clock_i);
        fails++;
        close_out();
    end
endmodule
